// [sim/meas_cfg_sva.sv]
// port assertions for the measurement config decoder
`timescale 1ns/1ps
`default_nettype none
module meas_cfg_sva (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// nvm and front end
	input wire logic nvmReq,
	input wire logic nvmAck,
	input wire logic [7:0] nvmIndex,
	input wire logic convActive,
	input wire meas_cfg_pkg::settings_t decoded
);
	import meas_cfg_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	logic [3:0] convCnt;
	// counts raw conversion cycles; saturates so long runs stay frozen
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b)
			convCnt <= 4'h0;
		else if (!convActive)
			convCnt <= 4'h0;
		else if (convCnt != 4'hf)
			convCnt <= convCnt + 4'h1;
	end
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wdone;
		!s_axi_awready ##1 s_axi_bvalid;
	endsequence
	a_write_answer: assert property (s_wtake |=> s_wdone)
		else $error("write answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_nvm_step: assert property (nvmReq && nvmAck && nvmIndex == 8'h12
		|=> nvmIndex == 8'h13) else $error("nvm index not advanced");
	a_nvm_end: assert property (nvmReq && nvmAck && nvmIndex == 8'h15
		|=> !nvmReq) else $error("nvm request not ended");
	a_gain_first: assert property (decoded.adcGain != 2'h0 |->
		decoded.firstGain inside {7'h06, 7'h0c, 7'h14, 7'h1e, 7'h28, 7'h3c,
		7'h50, 7'h78}) else $error("first gain out of set");
	a_abs_ground: assert property (decoded.negativeSenseToGround ==
		decoded.absoluteVoltageInputEn) else $error("ground tie mismatch");
	a_shift_zero: assert property (!decoded.offsetShiftEnable |->
		decoded.offsetShiftHundredths == 13'h0) else $error("shift without method");
	a_shift_gain: assert property (decoded.adcGain != 2'h0 |->
		decoded.adcGain == (decoded.offsetShiftEnable ? 2'h2 : 2'h1))
		else $error("adc gain mismatch");
	a_conv_freeze: assert property (convCnt >= 4'h8 |-> $stable(decoded))
		else $error("settings moved in conversion");
endmodule
bind measurement_config_decode meas_cfg_sva chk (.mclk, .rst_b, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .nvmReq, .nvmAck, .nvmIndex, .convActive, .decoded);
`default_nettype wire

// [sim/measurement_config_decode_test.sv]
// self-checking bench for the measurement config decoder
`timescale 1ns/1ps
`default_nettype none
module measurement_config_decode_test;
	import meas_cfg_pkg::*;
	logic mclk = 0, rst_b = 0, convActive = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, nvmReq, nvmAck;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] nvmIndex;
	logic [15:0] nvmData, w;
	logic [15:0] cfgWord = 16'hb2d5, lowWord = 16'h4c1d, highWord = 16'hc37e;
	logic [23:0] interruptThresholdOne;
	settings_t decoded;
	int err_count = 0, check_count = 0, cyc = 0, i;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	measurement_config_decode uut (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.nvmReq, .nvmIndex, .nvmAck, .nvmData, .convActive, .decoded,
		.interruptThresholdOne);
	nvm_model nvm (.mclk, .rst_b, .nvmReq, .nvmIndex, .nvmAck, .nvmData,
		.cfgWord, .lowWord, .highWord);
	initial forever #25 mclk = ~mclk;
	function automatic settings_t expDec(input logic [15:0] v);
		logic [6:0] g1[8] = '{7'h06, 7'h0c, 7'h14, 7'h1e, 7'h28, 7'h3c, 7'h50, 7'h78};
		logic [12:0] oh[8] = '{13'h0, 13'h2a3, 13'h4e2, 13'h785, 13'h9c4, 13'hc67,
			13'hf0a, 13'h10e5};
		settings_t s;
		s.firstGain = g1[v[2:0]];
		s.secondGainTenths = 5'h0b + 5'(v[5:3]);
		s.chopperInvert = v[6];
		s.adcCodeUnassigned = v[10:7] > 4'hc;
		s.adcResolution = s.adcCodeUnassigned ? 5'h18 : 5'h0c + 5'(v[10:7]);
		s.absoluteVoltageInputEn = v[11];
		s.negativeSenseToGround = v[11];
		s.offsetShiftEnable = v[15];
		s.offsetShiftHundredths = v[15] ? oh[v[14:12]] : 13'h0;
		s.adcGain = v[15] ? 2'h2 : 2'h1;
		s.offsetWithoutMethod = !v[15] && v[14:12] != 3'h0;
		return s;
	endfunction
	task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r);
		bq.push_back(r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_wstrb <= 4'h3;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle count assumed; only the bench timeout ends a hang
		forever begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
	endtask
	// settings land a few edges after a write or load
	task automatic decCheck(input logic [15:0] v);
		for (int n = 0; n < 40 && decoded !== expDec(v); n++)
			@(posedge mclk);
		chk("decoded", 64'(expDec(v)), 64'(decoded));
	endtask
	always @(posedge mclk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", 64'(bq.pop_front()), 64'(s_axi_bresp));
		if (s_axi_rvalid && s_axi_rready)
			chk("read", 64'(rq.pop_front()), 64'({s_axi_rresp, s_axi_rdata}));
		cyc++;
		if (cyc > 30000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		void'($urandom(9));
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		decCheck(cfgWord);
		chk("thresh", {highWord[7:0], lowWord}, interruptThresholdOne);
		$display("load test done");
		for (i = 0; i < 20; i++) begin
			if (i < 16)
				w = {i[0], i[0] ? i[3:1] : 3'h0, i[1], i[3:0], i[0], i[2:0], i[2:0]};
			else
				w = 16'($urandom);
			if (!w[15]) w[14:12] = 3'h0;
			axw(8'h48, w, RESP_OKAY);
			axr(8'h48, {RESP_OKAY, 16'h0, w});
			decCheck(w);
		end
		$display("decode sweep done");
		convActive <= 1'b1;
		repeat (8) @(posedge mclk);
		axw(8'h48, 16'h0f1a, RESP_OKAY);
		repeat (12) @(posedge mclk);
		chk("frozen", 64'(expDec(w)), 64'(decoded));
		convActive <= 1'b0;
		decCheck(16'h0f1a);
		$display("freeze test done");
		w = 16'($urandom);
		axw(8'h4c, w, RESP_OKAY);
		axw(8'h54, 16'hffa5, RESP_OKAY);
		repeat (6) @(posedge mclk);
		chk("thresh", {8'ha5, w}, interruptThresholdOne);
		axr(8'h54, {RESP_OKAY, 32'ha5});
		axw(8'h70, 16'h1234, RESP_SLVERR);
		axr(8'h70, {RESP_SLVERR, 32'h0});
		$display("threshold and map test done");
		cfgWord <= 16'hc6b3;
		highWord <= 16'h5a3c;
		axw(8'h84, 16'h0001, RESP_OKAY);
		decCheck(16'hc6b3);
		chk("thresh", {8'h3c, lowWord}, interruptThresholdOne);
		$display("reload test done");
		// deliberate pairing breach: shift must stay off, status flags it
		axw(8'h48, 16'h3000, RESP_OKAY);
		decCheck(16'h3000);
		axr(8'h80, {RESP_OKAY, 32'h11});
		$display("pairing breach test done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [sim/nvm_model.sv]
// nvm read port model answering with random latency
`timescale 1ns/1ps
`default_nettype none
module nvm_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// read port
	input wire logic nvmReq,
	input wire logic [7:0] nvmIndex,
	output logic nvmAck,
	output logic [15:0] nvmData,
	// stored words
	input wire logic [15:0] cfgWord,
	input wire logic [15:0] lowWord,
	input wire logic [15:0] highWord
);
	logic [1:0] delay;
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			nvmAck <= 1'b0;
			nvmData <= 16'h5aa5;
			delay <= 2'h0;
		end else begin
			nvmAck <= 1'b0;
			// junk outside an ack so a stale word cannot pass
			nvmData <= ~nvmData;
			if (nvmReq && !nvmAck) begin
				if (delay == 2'h0) begin
					nvmAck <= 1'b1;
					delay <= 2'($urandom_range(3));
					case (nvmIndex)
						8'h12: nvmData <= cfgWord;
						8'h13: nvmData <= lowWord;
						default: nvmData <= highWord;
					endcase
				end else
					delay <= delay - 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [verilog/config_field_decode.sv]
// combinational decode of the first measurement configuration word
`timescale 1ns/1ps
`default_nettype none
module config_field_decode (
	// raw word
	input wire meas_cfg_pkg::meas_config_t cfg,
	// decoded settings
	output meas_cfg_pkg::settings_t settings
);
	import meas_cfg_pkg::*;

	function automatic logic [6:0] firstGainOf(input logic [2:0] code);
		case (code)
			3'h0: return 7'h06;
			3'h1: return 7'h0c;
			3'h2: return 7'h14;
			3'h3: return 7'h1e;
			3'h4: return 7'h28;
			3'h5: return 7'h3c;
			3'h6: return 7'h50;
			default: return 7'h78;
		endcase
	endfunction

	function automatic logic [12:0] offsetOf(input logic [2:0] code);
		case (code)
			3'h0: return 13'h0000;
			3'h1: return 13'h02a3;
			3'h2: return 13'h04e2;
			3'h3: return 13'h0785;
			3'h4: return 13'h09c4;
			3'h5: return 13'h0c67;
			3'h6: return 13'h0f0a;
			default: return 13'h10e5;
		endcase
	endfunction

	always_comb begin
		settings.firstGain = firstGainOf(cfg.preampFirstGainSel);
		settings.secondGainTenths = SECOND_GAIN_BASE
			+ {2'h0, cfg.preampSecondGainSel};
		settings.chopperInvert = cfg.gainPolarity;
		settings.adcCodeUnassigned = (cfg.adcBits > ADC_MAX_CODE);
		// unassigned codes fall back to the widest conversion
		settings.adcResolution = settings.adcCodeUnassigned ?
			ADC_BASE_BITS + {1'b0, ADC_MAX_CODE} :
			ADC_BASE_BITS + {1'b0, cfg.adcBits};
		settings.absoluteVoltageInputEn = cfg.absoluteVoltageInputEn;
		settings.negativeSenseToGround = cfg.absoluteVoltageInputEn;
		settings.offsetShiftEnable = cfg.shiftMethod;
		settings.offsetShiftHundredths = cfg.shiftMethod ?
			offsetOf(cfg.offsetShift) : 13'h0000;
		settings.adcGain = cfg.shiftMethod ?
			ADC_GAIN_SHIFT : ADC_GAIN_PLAIN;
		settings.offsetWithoutMethod = !cfg.shiftMethod
			&& (cfg.offsetShift != 3'h0);
	end
endmodule
`default_nettype wire

// [verilog/meas_cfg_pkg.sv]
// shared types, register map and constants of the measurement config decoder
package meas_cfg_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONFIG_ONE = 8'h12;
	localparam logic [7:0] IDX_THRESH_LOW = 8'h13;
	localparam logic [7:0] IDX_THRESH_HIGH = 8'h15;
	localparam logic [7:0] IDX_STATUS = 8'h20;
	localparam logic [7:0] IDX_CONTROL = 8'h21;
	localparam logic [7:0] IDX_APPLIED = 8'h22;

	// reset values
	localparam logic [15:0] CONFIG_ONE_RESET = 16'h0000;
	localparam logic [15:0] THRESH_LOW_RESET = 16'h0000;
	localparam logic [7:0] THRESH_HIGH_RESET = 8'h00;

	// status and control bit positions
	localparam int STAT_LOAD_DONE = 0;
	localparam int STAT_CONV_BUSY = 1;
	localparam int STAT_PENDING = 2;
	localparam int STAT_ADC_UNASSIGNED = 3;
	localparam int STAT_OFFSET_NO_METHOD = 4;
	localparam int CTRL_RELOAD = 0;

	// converter constants
	localparam logic [4:0] ADC_BASE_BITS = 5'h0c;
	localparam logic [3:0] ADC_MAX_CODE = 4'hc;
	localparam logic [1:0] ADC_GAIN_PLAIN = 2'h1;
	localparam logic [1:0] ADC_GAIN_SHIFT = 2'h2;
	localparam logic [4:0] SECOND_GAIN_BASE = 5'h0b;

	// axi4-lite responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// first configuration word, msb first
	typedef struct packed {
		logic shiftMethod;
		logic [2:0] offsetShift;
		logic absoluteVoltageInputEn;
		logic [3:0] adcBits;
		logic gainPolarity;
		logic [2:0] preampSecondGainSel;
		logic [2:0] preampFirstGainSel;
	} meas_config_t;

	// decoded settings handed to the analog front end and converter
	typedef struct packed {
		logic [6:0] firstGain;
		logic [4:0] secondGainTenths;
		logic chopperInvert;
		logic [4:0] adcResolution;
		logic adcCodeUnassigned;
		logic absoluteVoltageInputEn;
		logic negativeSenseToGround;
		logic offsetShiftEnable;
		logic [12:0] offsetShiftHundredths;
		logic [1:0] adcGain;
		logic offsetWithoutMethod;
	} settings_t;

	// nvm load sequence, gray coded
	typedef enum logic [1:0] {
		LOAD_CONFIG = 2'h0,
		LOAD_LOW = 2'h1,
		LOAD_HIGH = 2'h3,
		RUNNING = 2'h2
	} nvm_state_t;

	function automatic logic [7:0] byteAddr(input logic [7:0] idx);
		return {idx[5:0], 2'h0};
	endfunction

endpackage

// [verilog/measurement_config_decode.sv]
// measurement configuration decoder with nvm load and axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
module measurement_config_decode (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// non-volatile memory read port
	output logic nvmReq,
	output logic [7:0] nvmIndex,
	input wire logic nvmAck,
	input wire logic [15:0] nvmData,
	// analog front end
	input wire logic convActive,
	output meas_cfg_pkg::settings_t decoded,
	output logic [23:0] interruptThresholdOne
);
	import meas_cfg_pkg::*;

	meas_config_t configOne;
	logic [15:0] threshLow;
	logic [7:0] threshHigh;
	meas_config_t appliedConfig;
	settings_t shadowSettings;
	nvm_state_t loadState;
	logic loadDone;
	logic convBusy;
	logic reloadReq;

	logic awHeld;
	logic [7:0] awAddr;
	logic wHeld;
	logic [31:0] wData;
	logic [3:0] wStrb;
	logic doWrite;
	logic pending;

	// conversion flag arrives from the analog side, outside our timing
	pin_sync convSync (
		.mclk(mclk),
		.rst_b(rst_b),
		.async(convActive),
		.level(convBusy)
	);

	config_field_decode fieldDecode (
		.cfg(configOne),
		.settings(shadowSettings)
	);

	function automatic logic isMapped(input logic [7:0] addr);
		return addr == byteAddr(IDX_CONFIG_ONE)
			|| addr == byteAddr(IDX_THRESH_LOW)
			|| addr == byteAddr(IDX_THRESH_HIGH)
			|| addr == byteAddr(IDX_STATUS)
			|| addr == byteAddr(IDX_CONTROL)
			|| addr == byteAddr(IDX_APPLIED);
	endfunction

	function automatic logic [15:0] mergeLanes(input logic [15:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] merged;
		merged = old;
		if (strb[0]) begin
			merged[7:0] = data[7:0];
		end
		if (strb[1]) begin
			merged[15:8] = data[15:8];
		end
		return merged;
	endfunction

	assign doWrite = awHeld && wHeld && !s_axi_bvalid;
	assign pending = (appliedConfig != configOne)
		|| (interruptThresholdOne != {threshHigh, threshLow});

	// write address channel, taken independently of write data
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
			s_axi_awready <= 1'b1;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld <= 1'b1;
			awAddr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (doWrite) begin
			awHeld <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			wHeld <= 1'b0;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_wready <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld <= 1'b1;
			wData <= s_axi_wdata;
			wStrb <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (doWrite) begin
			wHeld <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response, one cycle after both halves are held
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// software copies of the configuration words; nvm load wins a tie
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			configOne <= CONFIG_ONE_RESET;
			threshLow <= THRESH_LOW_RESET;
			threshHigh <= THRESH_HIGH_RESET;
		end else if (nvmReq && nvmAck) begin
			case (loadState)
				LOAD_CONFIG: begin
					configOne <= nvmData;
				end
				LOAD_LOW: begin
					threshLow <= nvmData;
				end
				LOAD_HIGH: begin
					threshHigh <= nvmData[7:0];
				end
				default: begin
				end
			endcase
		end else if (doWrite) begin
			if (awAddr == byteAddr(IDX_CONFIG_ONE)) begin
				configOne <= mergeLanes(configOne, wData, wStrb);
			end
			if (awAddr == byteAddr(IDX_THRESH_LOW)) begin
				threshLow <= mergeLanes(threshLow, wData, wStrb);
			end
			if (awAddr == byteAddr(IDX_THRESH_HIGH) && wStrb[0]) begin
				threshHigh <= wData[7:0];
			end
		end
	end

	// reload request from the control register, a one-cycle pulse
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			reloadReq <= 1'b0;
		end else begin
			reloadReq <= doWrite && awAddr == byteAddr(IDX_CONTROL)
				&& wStrb[0] && wData[CTRL_RELOAD];
		end
	end

	// nvm load after reset and on request
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			loadState <= LOAD_CONFIG;
			loadDone <= 1'b0;
			nvmReq <= 1'b0;
			nvmIndex <= IDX_CONFIG_ONE;
		end else begin
			case (loadState)
				LOAD_CONFIG: begin
					nvmReq <= 1'b1;
					nvmIndex <= IDX_CONFIG_ONE;
					if (nvmReq && nvmAck) begin
						loadState <= LOAD_LOW;
						nvmIndex <= IDX_THRESH_LOW;
					end
				end
				LOAD_LOW: begin
					if (nvmAck) begin
						loadState <= LOAD_HIGH;
						nvmIndex <= IDX_THRESH_HIGH;
					end
				end
				LOAD_HIGH: begin
					if (nvmAck) begin
						loadState <= RUNNING;
						nvmReq <= 1'b0;
						loadDone <= 1'b1;
					end
				end
				RUNNING: begin
					if (reloadReq) begin
						loadState <= LOAD_CONFIG;
						loadDone <= 1'b0;
					end
				end
				default: begin
					loadState <= LOAD_CONFIG;
					nvmReq <= 1'b0;
				end
			endcase
		end
	end

	// settings only change while the synchronised convBusy is low, so they can still move in the first few edges after convActive rises
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			appliedConfig <= CONFIG_ONE_RESET;
			decoded <= '0;
			interruptThresholdOne <= 24'h000000;
		end else if (loadDone && !convBusy) begin
			appliedConfig <= configOne;
			decoded <= shadowSettings;
			interruptThresholdOne <= {threshHigh, threshLow};
		end
	end

	// read channel, data one cycle after the address is taken
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_axi_rdata <= 32'h00000000;
			case (s_axi_araddr)
				byteAddr(IDX_CONFIG_ONE): begin
					s_axi_rdata[15:0] <= configOne;
				end
				byteAddr(IDX_THRESH_LOW): begin
					s_axi_rdata[15:0] <= threshLow;
				end
				byteAddr(IDX_THRESH_HIGH): begin
					s_axi_rdata[7:0] <= threshHigh;
				end
				byteAddr(IDX_STATUS): begin
					s_axi_rdata[STAT_LOAD_DONE] <= loadDone;
					s_axi_rdata[STAT_CONV_BUSY] <= convBusy;
					s_axi_rdata[STAT_PENDING] <= pending;
					s_axi_rdata[STAT_ADC_UNASSIGNED] <=
						shadowSettings.adcCodeUnassigned;
					// other party broke the offset/method pairing
					s_axi_rdata[STAT_OFFSET_NO_METHOD] <=
						shadowSettings.offsetWithoutMethod;
				end
				byteAddr(IDX_APPLIED): begin
					s_axi_rdata[15:0] <= appliedConfig;
				end
				default: begin
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// [verilog/pin_sync.sv]
// three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// level in and out
	input wire logic async,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= async;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// change only counts once stages two and three agree
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			level <= 1'b0;
		end else if (s2 == s3) begin
			level <= s3;
		end
	end
endmodule
`default_nettype wire
